/* src/kps_scan_regs.svh */
`ifndef KPS_SCAN_REGS_SVH
`define KPS_SCAN_REGS_SVH

// matrix size
`define KPS_ROWS 5
`define KPS_COLS 5

// row pattern states, the pattern itself is the state
`define KPS_IDLE 5'h00
`define KPS_SCAN0 5'h1e
`define KPS_SCAN1 5'h1d
`define KPS_SCAN2 5'h1b
`define KPS_SCAN3 5'h17
`define KPS_SCAN4 5'h0f

// rotator preset, zero on the first row
`define KPS_ROT_PRESET 5'h1e

// reset values of the debounce flags
`define KPS_HOLD_RESET 1'h0
`define KPS_IRQ_RESET 1'h0

`endif

/* src/kps_scan_pkg.sv */
`include "kps_scan_regs.svh"

package kps_scan_pkg;

    // scan states, coded as the row pattern
    typedef enum logic [4:0] {
        KPS_ST_IDLE  = `KPS_IDLE,
        KPS_ST_SCAN0 = `KPS_SCAN0,
        KPS_ST_SCAN1 = `KPS_SCAN1,
        KPS_ST_SCAN2 = `KPS_SCAN2,
        KPS_ST_SCAN3 = `KPS_SCAN3,
        KPS_ST_SCAN4 = `KPS_SCAN4
    } kps_state_t;

    typedef logic [`KPS_COLS-1:0] kps_cols_t;
    typedef logic [`KPS_ROWS-1:0] kps_rows_t;

    // any column pulled low by a closed key
    function automatic logic kps_any_low(input kps_cols_t cols);
        kps_any_low = ~(&cols);
    endfunction

endpackage

/* src/kps_scan_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface kps_scan_if;
    import kps_scan_pkg::*;

    kps_cols_t columns;
    logic hold_scan;
    logic key_irq;

    modport scanner (
        output columns,
        input hold_scan,
        input key_irq
    );

    modport debounce (
        input columns,
        output hold_scan,
        output key_irq
    );
endinterface

`default_nettype wire

/* src/kps_scan_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "kps_scan_regs.svh"

module kps_scan_debounce
    import kps_scan_pkg::*;
(
    // clock and synchronised reset
    input wire logic clock,
    input wire logic rst_sync_b,
    // link to the scanner
    kps_scan_if.debounce dbus
);

    logic any_low;
    logic hold_reg;
    logic hold_next;
    logic irq_reg;
    logic irq_next;

    // column decode and flag next values
    assign any_low = kps_any_low(dbus.columns);
    assign hold_next = any_low;
    assign irq_next = hold_reg & any_low;

    // flags update on the falling edge
    always_ff @(negedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hold_reg <= `KPS_HOLD_RESET;
            irq_reg <= `KPS_IRQ_RESET;
        end else begin
            hold_reg <= hold_next;
            irq_reg <= irq_next;
        end
    end

    assign dbus.hold_scan = hold_reg;
    assign dbus.key_irq = irq_reg;

endmodule

`default_nettype wire

/* src/kps_scan_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "kps_scan_regs.svh"

// Function
// - rows get one rotating zero, row 0 upward, repeating every five clocks
// - row register on rising edge, freeze and interrupt flags on falling edge
// - each falling edge, hold_scan set if any column low, cleared if all high
// - interrupt only when hold_scan already set and a column still low
// - pattern is the state; idle all zeros always goes to first scan state
// - advance only while hold_scan clear, otherwise keep the pressed row low
// - active-low reset clears row register (rotator: loads 11110), hold_scan and interrupt asynchronously
// - scanning stays stopped while key closed, resumes when columns all high
// - controller can read the row pattern back, one clock behind row_drive
// - controller can read the raw column levels
// - optional rotator preset to 11110, stepping stopped by hold_scan
module kps_scan_top
    import kps_scan_pkg::*;
#(
    parameter bit USE_ROTATOR = 1'b0
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // keypad matrix
    input wire logic [`KPS_COLS-1:0] column_sense,
    output logic [`KPS_ROWS-1:0] row_drive,
    // toward the controller
    output logic key_irq,
    output logic hold_scan,
    output logic [`KPS_ROWS-1:0] row_readback,
    output logic [`KPS_COLS-1:0] column_readback
);

    logic rst_meta_reg;
    logic rst_sync_reg;
    kps_rows_t row_reg;
    kps_rows_t row_next;
    kps_rows_t row_in_reg;
    kps_cols_t col_in_reg;

    kps_scan_if sbus ();

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'h0;
            rst_sync_reg <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // columns feed the falling-edge debounce stage
    assign sbus.columns = column_sense;

    kps_scan_debounce u_debounce (
        .clock(clock),
        .rst_sync_b(rst_sync_reg),
        .dbus(sbus.debounce)
    );

    generate
        if (USE_ROTATOR) begin : g_rotator
            // shift the zero one row up, frozen while a key is held
            assign row_next = sbus.hold_scan ? row_reg :
                              {row_reg[`KPS_ROWS-2:0], row_reg[`KPS_ROWS-1]};

            always_ff @(posedge clock or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    row_reg <= `KPS_ROT_PRESET;
                end else begin
                    row_reg <= row_next;
                end
            end
        end else begin : g_fsm
            kps_state_t state_reg;
            kps_state_t state_next;
            logic go;

            assign go = ~sbus.hold_scan;

            // next scan state, pattern doubles as state
            always_comb begin
                case (state_reg)
                    KPS_ST_IDLE: begin
                        state_next = KPS_ST_SCAN0;
                    end
                    KPS_ST_SCAN0: begin
                        state_next = go ? KPS_ST_SCAN1 : KPS_ST_SCAN0;
                    end
                    KPS_ST_SCAN1: begin
                        state_next = go ? KPS_ST_SCAN2 : KPS_ST_SCAN1;
                    end
                    KPS_ST_SCAN2: begin
                        state_next = go ? KPS_ST_SCAN3 : KPS_ST_SCAN2;
                    end
                    KPS_ST_SCAN3: begin
                        state_next = go ? KPS_ST_SCAN4 : KPS_ST_SCAN3;
                    end
                    KPS_ST_SCAN4: begin
                        state_next = go ? KPS_ST_SCAN0 : KPS_ST_SCAN4;
                    end
                    default: begin
                        state_next = KPS_ST_IDLE;
                    end
                endcase
            end

            // scan register on the rising edge
            always_ff @(posedge clock or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    state_reg <= KPS_ST_IDLE;
                end else begin
                    state_reg <= state_next;
                end
            end

            assign row_reg = kps_rows_t'(state_reg);
            assign row_next = kps_rows_t'(state_next);
        end
    endgenerate

    // row readback flop, one per row, copies row_drive one clock later
    genvar gi;
    generate
        for (gi = 0; gi < `KPS_ROWS; gi++) begin : g_row
            always_ff @(posedge clock or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    row_in_reg[gi] <= 1'h1;
                end else begin
                    row_in_reg[gi] <= row_drive[gi];
                end
            end
        end
    endgenerate

    // outputs toward the pins and the controller
    always_ff @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            row_drive <= USE_ROTATOR ? `KPS_ROT_PRESET : `KPS_IDLE;
            col_in_reg <= {`KPS_COLS{1'h1}};
        end else begin
            row_drive <= row_next;
            col_in_reg <= column_sense;
        end
    end

    assign row_readback = row_in_reg;
    assign column_readback = col_in_reg;
    assign key_irq = sbus.key_irq;
    assign hold_scan = sbus.hold_scan;

endmodule

`default_nettype wire

/* test/kps_keypad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module kps_keypad_model (
    // key control
    input wire logic pressed,
    input wire logic [2:0] key_row,
    input wire logic [2:0] key_col,
    // matrix lines
    input wire logic [4:0] row_drive,
    output logic [4:0] column_sense
);
    wire logic path;
    // closed key passes its row level, contacts settle within a clock
    assign path = pressed && (row_drive[key_row] == 1'b0);
    assign column_sense = path ? ~(5'h01 << key_col) : 5'h1f; // pull-ups
endmodule
`default_nettype wire

/* test/kps_scan_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module kps_scan_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // watched ports
    input wire logic [4:0] column_sense,
    input wire logic [4:0] row_drive,
    input wire logic key_irq,
    input wire logic hold_scan,
    input wire logic [4:0] row_readback,
    input wire logic [4:0] column_readback
);
    // debounce flags on the falling edge
    a_hold_sets: assert property (@(negedge clock) disable iff (!rst_b) ~&column_sense |=> hold_scan)
        else $error("hold_scan not set");
    a_hold_clears: assert property (@(negedge clock) disable iff (!rst_b) &column_sense |=> !hold_scan)
        else $error("hold_scan not cleared");
    a_irq_sets: assert property (@(negedge clock) disable iff (!rst_b) hold_scan && ~&column_sense |=> key_irq)
        else $error("key_irq not set");
    a_irq_clears: assert property (@(negedge clock) disable iff (!rst_b) !hold_scan || &column_sense |=> !key_irq)
        else $error("key_irq without cause");
    // row scan, reset and readbacks on the rising edge
    a_row_frozen: assert property (@(posedge clock) disable iff (!rst_b) hold_scan |=> $stable(row_drive))
        else $error("row moved while held");
    a_row_steps: assert property (@(posedge clock) disable iff (!rst_b)
        !hold_scan && row_drive != 5'h00 |=> row_drive == {$past(row_drive[3:0]), $past(row_drive[4])})
        else $error("row did not step");
    a_idle_exit: assert property (@(posedge clock) disable iff (!rst_b) row_drive == 5'h00 |-> ##[1:3] row_drive == 5'h1e)
        else $error("idle not left");
    a_single_zero: assert property (@(posedge clock) disable iff (!rst_b) row_drive != 5'h00 |-> $onehot(~row_drive))
        else $error("row pattern not single zero");
    a_reset_clear: assert property (@(posedge clock) !rst_b ##1 !rst_b |-> row_drive == 5'h00 && !key_irq && !hold_scan)
        else $error("reset did not clear");
    a_col_copy: assert property (@(posedge clock) disable iff (!rst_b) 1'b1 |=> column_readback == $past(column_sense))
        else $error("column_readback wrong");
    a_row_copy: assert property (@(posedge clock) disable iff (!rst_b) row_drive != 5'h00 |=> row_readback == $past(row_drive))
        else $error("row_readback wrong");
endmodule
bind kps_scan_top kps_scan_checker i_chk (.clock(clock), .rst_b(rst_b), .column_sense(column_sense),
    .row_drive(row_drive), .key_irq(key_irq), .hold_scan(hold_scan), .row_readback(row_readback),
    .column_readback(column_readback));
`default_nettype wire

/* test/test_kps_scan_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_kps_scan_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic pressed = 1'b0;
    logic [2:0] key_row = 3'h0;
    logic [2:0] key_col = 3'h0;
    logic [4:0] column_sense, row_drive, row_readback, column_readback;
    logic key_irq, hold_scan;
    int fails = 0;
    int cmp_count = 0;
    // clock and watchdog
    always #5 clock = ~clock;
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
    kps_scan_top i_dut (.clock(clock), .rst_b(rst_b), .column_sense(column_sense), .row_drive(row_drive),
        .key_irq(key_irq), .hold_scan(hold_scan), .row_readback(row_readback), .column_readback(column_readback));
    kps_keypad_model i_keys (.pressed(pressed), .key_row(key_row), .key_col(key_col), .row_drive(row_drive),
        .column_sense(column_sense));
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // rotation from the first row, with wrap
    task automatic t_scan();
        logic [4:0] exp;
        exp = 5'h1e;
        for (int i = 0; i < 8 && row_drive !== 5'h1e; i++) tick();
        for (int i = 0; i < 7; i++) begin
            chk("row_drive", exp, row_drive);
            tick();
            exp = {exp[3:0], exp[4]};
        end
    endtask
    // press, freeze, interrupt, read back, release
    task automatic t_key(input int r, input int c);
        logic [4:0] pat;
        pat = ~(5'h01 << r);
        @(posedge clock);
        key_row <= 3'(r);
        key_col <= 3'(c);
        pressed <= 1'b1;
        for (int i = 0; i < 20 && key_irq !== 1'b1; i++) tick();
        chk("key_irq", 5'h01, {4'h0, key_irq});
        chk("hold_scan", 5'h01, {4'h0, hold_scan});
        tick();
        tick();
        chk("column_readback", ~(5'h01 << c), column_readback);
        chk("row_readback", pat, row_readback);
        chk("row_drive", pat, row_drive);
        @(posedge clock);
        pressed <= 1'b0;
        @(negedge clock);
        #1;
        chk("key_irq", 5'h00, {4'h0, key_irq});
        chk("hold_scan", 5'h00, {4'h0, hold_scan});
        tick();
        chk("row_drive", {pat[3:0], pat[4]}, row_drive);
    endtask
    // key low for one falling edge only
    task automatic t_bounce();
        @(posedge clock);
        key_row <= 3'h2;
        key_col <= 3'h0;
        pressed <= 1'b1;
        for (int i = 0; i < 20 && hold_scan !== 1'b1; i++) @(posedge clock);
        pressed <= 1'b0;
        @(negedge clock);
        #1;
        chk("key_irq", 5'h00, {4'h0, key_irq});
        chk("hold_scan", 5'h00, {4'h0, hold_scan});
    endtask
    // reset in mid-press, then scan again
    task automatic t_reset(input bit mid);
        if (mid) begin
            @(posedge clock);
            pressed <= 1'b1;
            for (int i = 0; i < 20 && key_irq !== 1'b1; i++) tick();
            @(posedge clock);
            rst_b <= 1'b0;
            pressed <= 1'b0;
        end
        repeat (16) tick();
        chk("row_drive", 5'h00, row_drive);
        chk("flags", 5'h00, {3'h0, key_irq, hold_scan});
        @(posedge clock);
        rst_b <= 1'b1;
        t_scan();
    endtask
    initial begin
        t_reset(1'b0);
        for (int r = 0; r < 5; r++) t_key(r, (r * 2 + 1) % 5);
        t_bounce();
        t_reset(1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
